// File: siirm_pkg.sv
// Purpose: Shared constants and types for the scan I/O image engine
// Assumes: 40 MHz system clock
// Notes:   Relay numbers for X/Y arrive as three octal digit nibbles
package siirm_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_KHZ       = 40000;
  localparam int FILT_MS       = 10;
  localparam int FILT_CYC      = FILT_MS * CLK_KHZ;
  localparam int OSC_PERIOD_MS = 100;
  localparam int OSC_HALF_CYC  = OSC_PERIOD_MS * CLK_KHZ / 2;
  localparam int CSCAN_CYC     = 4000;  // Constant scan period, cycles

  // ****************************************************************
  // Address spaces
  // ****************************************************************
  localparam int IO_PTS      = 256;
  localparam int IO_AW       = 8;
  localparam int MNUM_W      = 14;
  localparam int MRAM_DEPTH  = 1536;
  localparam int MRAM_AW     = 11;
  localparam logic [MNUM_W-1:0] M_GEN_END   = 14'd499;
  localparam logic [MNUM_W-1:0] M_FIX_START = 14'd1024;
  localparam logic [MNUM_W-1:0] M_FIX_END   = 14'd1535;
  localparam logic [MNUM_W-1:0] M_SPC_START = 14'd8000;
  localparam logic [MNUM_W-1:0] M_SPC_END   = 14'd8511;
  localparam logic [MNUM_W-1:0] M_RUN_MON   = 14'd8000;
  localparam logic [MNUM_W-1:0] M_INIT_PLS  = 14'd8002;
  localparam logic [MNUM_W-1:0] M_OSC_100   = 14'd8012;
  localparam logic [MNUM_W-1:0] M_KEEP_MEM  = 14'd8033;
  localparam logic [MNUM_W-1:0] M_OUT_INH   = 14'd8034;
  localparam logic [MNUM_W-1:0] M_CONST_SCN = 14'd8039;
  localparam logic [MNUM_W-1:0] RET_START_RST = 14'd500;

  typedef enum logic [1:0] {
    SP_X = 2'h0,
    SP_Y = 2'h1,
    SP_M = 2'h2
  } siirm_space_e;

  typedef struct packed {
    siirm_space_e      space;
    logic [MNUM_W-1:0] num;
  } siirm_addr_s;

  typedef enum logic [5:0] {
    ST_CLEAR  = 6'h01,
    ST_IDLE   = 6'h02,
    ST_SAMPLE = 6'h04,
    ST_EXEC   = 6'h08,
    ST_LATCH  = 6'h10,
    ST_WAIT   = 6'h20
  } siirm_state_e;

endpackage

// File: siirm_bit_ram.sv
// Purpose: Bit-wide storage for general and retentive auxiliary relays
// Assumes: Contents survive reset, standing in for battery backed cells
// Notes:   Read data come out of a register one cycle after the address
`timescale 1ns/1ps
module siirm_bit_ram
  import siirm_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               we_i,
  input  wire logic [MRAM_AW-1:0] waddr_i,
  input  wire logic               wdata_i,
  input  wire logic [MRAM_AW-1:0] raddr_i,
  output logic                    rdata_o
);

  logic mem [MRAM_DEPTH];

  // ****************************************************************
  // Storage, no reset so retentive bits outlive power loss
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule

// File: siirm_scan_engine.sv
// Purpose: Scan engine holding input, output and auxiliary relay images
// Assumes: Program sequencer outside issues accesses during execution
// Notes:   Reset stands for power-up; long counts are top parameters
//
// Overview of operation
// - X and Y numbers decode as octal digits
// - X and Y each span 000 to 377 octal
// - Closed input circuit reads one, open zero
// - Program writes never touch the input image
// - Sample all inputs before any program step
// - Input changes during execution wait one scan
// - Each input filtered about 10 ms both ways
// - Execution starts at step zero against images
// - Output latch loads only after program end
// - Auxiliary relays in four decimal ranges
// - Fixed retentive range fixed, split configurable
// - Power loss clears general and output relays
// - Retentive relays keep state from first scan
// - Run monitor, init pulse, 100 ms oscillator
// - Keep memory, output inhibit, constant scan
// - Control relays act on drive and end
// - One contact per output, image freely readable
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module siirm_scan_engine
  import siirm_pkg::*;
#(
  parameter int FILT_CYCLES  = FILT_CYC,
  parameter int OSC_CYCLES   = OSC_HALF_CYC,
  parameter int CSCAN_CYCLES = CSCAN_CYC
)
(
  input  wire logic                mclk_i,
  input  wire logic                reset_i,
  input  wire logic                run_i,
  input  wire logic [MNUM_W-1:0]   ret_start_i,
  input  wire logic [IO_PTS-1:0]   term_in_i,
  output logic      [IO_PTS-1:0]   term_out_o,
  output logic                     exec_o,
  output logic      [15:0]         step_o,
  input  wire logic                step_adv_i,
  input  wire logic                end_i,
  input  wire siirm_addr_s         acc_addr_i,
  input  wire logic                acc_wdata_i,
  input  wire logic                acc_wr_i,
  input  wire logic                acc_rd_i,
  output logic                     acc_rdata_o,
  output logic                     acc_err_o
);

  // ****************************************************************
  // Input filters
  // ****************************************************************
  logic [IO_PTS-1:0] filt_ff;
  logic [IO_PTS-1:0] nxt_filt;

  // Per input: a changed level must hold for the full filter time
  generate
    for (genvar g = 0; g < IO_PTS; g++) begin : g_filt
      logic [19:0] cnt_ff;
      logic [19:0] nxt_cnt;
      always_comb begin
        nxt_cnt     = 20'h0;
        nxt_filt[g] = filt_ff[g];
        if (term_in_i[g] != filt_ff[g]) begin
          nxt_cnt = cnt_ff + 20'h1;
          if (cnt_ff >= 20'(FILT_CYCLES - 1)) begin
            nxt_cnt     = 20'h0;
            nxt_filt[g] = term_in_i[g];  // High = circuit closed
          end
        end
      end
      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          cnt_ff <= 20'h0;
        end else begin
          cnt_ff <= nxt_cnt;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      filt_ff <= '0;
    end else begin
      filt_ff <= nxt_filt;
    end
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic [IO_AW-1:0] io_idx;
  logic             io_ok;
  logic             m_ram;
  logic             m_spc;
  logic [MRAM_AW-1:0] m_idx;

  // Three octal digits; any nibble of 8 or 9, or top digit above 3,
  // has no relay, so 017 is followed directly by 020
  always_comb begin
    io_idx = {acc_addr_i.num[9:8], acc_addr_i.num[6:4],
              acc_addr_i.num[2:0]};
    io_ok  = (acc_addr_i.num[13:10] == 4'h0) &&
             (acc_addr_i.num[7] == 1'b0) &&
             (acc_addr_i.num[3] == 1'b0);
    m_ram  = (acc_addr_i.num <= M_FIX_END);
    m_spc  = (acc_addr_i.num >= M_SPC_START) &&
             (acc_addr_i.num <= M_SPC_END);
    m_idx  = acc_addr_i.num[MRAM_AW-1:0];
  end

  // ****************************************************************
  // Scan sequencer
  // ****************************************************************
  siirm_state_e      state_ff;
  siirm_state_e      nxt_state;
  logic [15:0]       step_ff;
  logic [15:0]       nxt_step;
  logic [31:0]       scan_cnt_ff;
  logic [31:0]       nxt_scan_cnt;
  logic [MRAM_AW-1:0] clr_ff;
  logic [MRAM_AW-1:0] nxt_clr;
  logic              first_ff;
  logic              nxt_first;
  logic              pulse_ff;
  logic              nxt_pulse;
  logic              cscan_act_ff;
  logic [MNUM_W-1:0] gen_lim;

  // Split point may move inside 0..1023 only; fixed range is immune
  always_comb begin
    gen_lim = (ret_start_i > M_FIX_START) ? M_FIX_START : ret_start_i;
  end

  always_comb begin
    nxt_state    = state_ff;
    nxt_step     = step_ff;
    nxt_clr      = clr_ff;
    nxt_first    = first_ff;
    nxt_pulse    = pulse_ff;
    nxt_scan_cnt = scan_cnt_ff + 32'h1;
    unique case (state_ff)
      ST_CLEAR: begin
        // Wipe general relays only; retentive cells stay
        nxt_clr = clr_ff + 11'h1;
        if ({3'h0, clr_ff} + 14'h1 >= gen_lim) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        nxt_first = 1'b1;
        if (run_i) begin
          nxt_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        nxt_state    = ST_EXEC;
        nxt_step     = 16'h0;  // Start at step 0
        nxt_scan_cnt = 32'h0;
        nxt_pulse    = first_ff;  // Init pulse lasts one scan
        nxt_first    = 1'b0;
      end
      ST_EXEC: begin
        if (end_i) begin
          nxt_state = ST_LATCH;
        end else if (step_adv_i) begin
          nxt_step = step_ff + 16'h1;
        end
      end
      ST_LATCH: begin
        if (!run_i) begin
          nxt_state = ST_IDLE;
        end else if (cscan_act_ff) begin
          nxt_state = ST_WAIT;
        end else begin
          nxt_state = ST_SAMPLE;
        end
      end
      ST_WAIT: begin
        // Pad a short scan out to CSCAN_CYCLES; a longer scan is not shortened
        if (!run_i) begin
          nxt_state = ST_IDLE;
        end else if (scan_cnt_ff >= 32'(CSCAN_CYCLES - 1)) begin
          nxt_state = ST_SAMPLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff    <= ST_CLEAR;
      step_ff     <= 16'h0;
      clr_ff      <= 11'h0;
      first_ff    <= 1'b1;
      pulse_ff    <= 1'b0;
      scan_cnt_ff <= 32'h0;
    end else begin
      state_ff    <= nxt_state;
      step_ff     <= nxt_step;
      clr_ff      <= nxt_clr;
      first_ff    <= nxt_first;
      pulse_ff    <= nxt_pulse;
      scan_cnt_ff <= nxt_scan_cnt;
    end
  end

  // ****************************************************************
  // 100 ms oscillator flag
  // ****************************************************************
  logic [31:0] osc_cnt_ff;
  logic [31:0] nxt_osc_cnt;
  logic        osc_ff;
  logic        nxt_osc;

  always_comb begin
    nxt_osc_cnt = osc_cnt_ff + 32'h1;
    nxt_osc     = osc_ff;
    if (osc_cnt_ff >= 32'(OSC_CYCLES - 1)) begin
      nxt_osc_cnt = 32'h0;
      nxt_osc     = ~osc_ff;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      osc_cnt_ff <= 32'h0;
      osc_ff     <= 1'b0;
    end else begin
      osc_cnt_ff <= nxt_osc_cnt;
      osc_ff     <= nxt_osc;
    end
  end

  // ****************************************************************
  // Images, special control relays and output latch
  // ****************************************************************
  logic [IO_PTS-1:0] x_img_ff;
  logic [IO_PTS-1:0] nxt_x_img;
  logic [IO_PTS-1:0] y_img_ff;
  logic [IO_PTS-1:0] nxt_y_img;
  logic [IO_PTS-1:0] y_lat_ff;
  logic [IO_PTS-1:0] nxt_y_lat;
  logic [2:0]        spc_img_ff;  // Coil images: keep, inhibit, cscan
  logic [2:0]        nxt_spc_img;
  logic [2:0]        spc_act_ff;  // Values steering the engine
  logic [2:0]        nxt_spc_act;
  logic              prg_wr;

  assign prg_wr = acc_wr_i && (state_ff == ST_EXEC);
  assign cscan_act_ff = spc_act_ff[2];

  always_comb begin
    nxt_x_img   = x_img_ff;
    nxt_y_img   = y_img_ff;
    nxt_y_lat   = y_lat_ff;
    nxt_spc_img = spc_img_ff;
    nxt_spc_act = spc_act_ff;
    // Single sampling pass; filter output otherwise ignored
    if (state_ff == ST_SAMPLE) begin
      nxt_x_img = filt_ff;
    end
    // Program results go to images; X space is never a target
    if (prg_wr && acc_addr_i.space == SP_Y && io_ok) begin
      nxt_y_img[io_idx] = acc_wdata_i;
    end
    if (prg_wr && acc_addr_i.space == SP_M) begin
      unique case (acc_addr_i.num)
        M_KEEP_MEM:  nxt_spc_img[0] = acc_wdata_i;
        M_OUT_INH:   nxt_spc_img[1] = acc_wdata_i;
        M_CONST_SCN: nxt_spc_img[2] = acc_wdata_i;
        default:     nxt_spc_img    = spc_img_ff;
      endcase
      nxt_spc_act = nxt_spc_img;  // Effect at coil drive
    end
    // After the last step: control relays re-applied, image to latch
    if (state_ff == ST_LATCH) begin
      nxt_spc_act = spc_img_ff;
      nxt_y_lat   = y_img_ff;
    end
    // Leaving run clears outputs unless memory keep is driven
    if (state_ff == ST_IDLE && !spc_act_ff[0]) begin
      nxt_y_img = '0;
      nxt_y_lat = '0;
    end
  end

  // Async reset is power-up: outputs and controls come back OFF
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      x_img_ff   <= '0;
      y_img_ff   <= '0;
      y_lat_ff   <= '0;
      spc_img_ff <= 3'h0;
      spc_act_ff <= 3'h0;
    end else begin
      x_img_ff   <= nxt_x_img;
      y_img_ff   <= nxt_y_img;
      y_lat_ff   <= nxt_y_lat;
      spc_img_ff <= nxt_spc_img;
      spc_act_ff <= nxt_spc_act;
    end
  end

  // Latch bit n drives terminal n only; inhibit masks all
  always_comb begin
    term_out_o = spc_act_ff[1] ? '0 : y_lat_ff;
  end

  assign exec_o = (state_ff == ST_EXEC);
  assign step_o = step_ff;

  // ****************************************************************
  // Auxiliary relay storage
  // ****************************************************************
  logic               ram_we;
  logic [MRAM_AW-1:0] ram_wa;
  logic               ram_wd;
  logic               ram_q;

  // Clearing owns the write port before the first scan
  always_comb begin
    ram_we = 1'b0;
    ram_wa = m_idx;
    ram_wd = acc_wdata_i;
    if (state_ff == ST_CLEAR) begin
      // No write at all when the whole lower range is retentive
      ram_we = ({3'h0, clr_ff} < gen_lim);
      ram_wa = clr_ff;
      ram_wd = 1'b0;
    end else if (prg_wr && acc_addr_i.space == SP_M && m_ram) begin
      ram_we = 1'b1;
    end
  end

  siirm_bit_ram u_mram (
    .mclk_i  (mclk_i),
    .we_i    (ram_we),
    .waddr_i (ram_wa),
    .wdata_i (ram_wd),
    .raddr_i (m_idx),
    .rdata_o (ram_q)
  );

  // ****************************************************************
  // Read port, data one cycle after the strobe
  // ****************************************************************
  logic rd_bit_ff;
  logic nxt_rd_bit;
  logic rd_ram_ff;
  logic nxt_rd_ram;
  logic err_ff;
  logic nxt_err;

  // Undefined special numbers read zero and flag the access
  always_comb begin
    nxt_rd_bit = 1'b0;
    nxt_rd_ram = 1'b0;
    nxt_err    = 1'b0;
    if (acc_rd_i || acc_wr_i) begin
      unique case (acc_addr_i.space)
        SP_X: begin
          nxt_rd_bit = io_ok ? x_img_ff[io_idx] : 1'b0;
          nxt_err    = !io_ok || acc_wr_i;
        end
        SP_Y: begin
          nxt_rd_bit = io_ok ? y_img_ff[io_idx] : 1'b0;
          nxt_err    = !io_ok;
        end
        SP_M: begin
          nxt_rd_ram = m_ram;
          unique case (acc_addr_i.num)
            M_RUN_MON:   nxt_rd_bit = (state_ff != ST_IDLE) &&
                                      (state_ff != ST_CLEAR);
            M_INIT_PLS:  nxt_rd_bit = pulse_ff;
            M_OSC_100:   nxt_rd_bit = osc_ff;
            M_KEEP_MEM:  nxt_rd_bit = spc_img_ff[0];
            M_OUT_INH:   nxt_rd_bit = spc_img_ff[1];
            M_CONST_SCN: nxt_rd_bit = spc_img_ff[2];
            default:     nxt_err    = !m_ram;
          endcase
          if (m_spc && acc_wr_i &&
              (acc_addr_i.num == M_RUN_MON ||
               acc_addr_i.num == M_INIT_PLS ||
               acc_addr_i.num == M_OSC_100)) begin
            nxt_err = 1'b1;  // Read-only flags
          end
        end
        default: begin
          nxt_err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_bit_ff <= 1'b0;
      rd_ram_ff <= 1'b0;
      err_ff    <= 1'b0;
    end else begin
      rd_bit_ff <= nxt_rd_bit;
      rd_ram_ff <= nxt_rd_ram;
      err_ff    <= nxt_err;
    end
  end

  // Both sources are registers, so the answer is glitch free
  assign acc_rdata_o = rd_ram_ff ? ram_q : rd_bit_ff;
  assign acc_err_o   = err_ff;

endmodule

// File: siirm_scan_engine_asserts.sv
// Purpose: Port checker for the scan I/O image engine
// Assumes: Bound to every engine instance, one clock domain
// Notes:   Count parameters are handed on by the bind
`timescale 1ns/1ps
module siirm_scan_engine_asserts
  import siirm_pkg::*;
#(
  parameter int FILT_CYCLES  = FILT_CYC,
  parameter int OSC_CYCLES   = OSC_HALF_CYC,
  parameter int CSCAN_CYCLES = CSCAN_CYC
)
(
  input wire logic              mclk_i,
  input wire logic              reset_i,
  input wire logic              exec_o,
  input wire logic [15:0]       step_o,
  input wire logic              step_adv_i,
  input wire logic              end_i,
  input wire siirm_addr_s       acc_addr_i,
  input wire logic              acc_wr_i,
  input wire logic              acc_rd_i,
  input wire logic              acc_rdata_o,
  input wire logic              acc_err_o,
  input wire logic [IO_PTS-1:0] term_out_o
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic bad_oct;
  logic ok_y;
  // Digit checks shared by the address properties
  assign bad_oct = acc_addr_i.num[3] | acc_addr_i.num[7] |
                   (acc_addr_i.num[11:8] > 4'h3);
  assign ok_y = (acc_addr_i.space == SP_Y) & ~bad_oct &
                (acc_addr_i.num[13:12] == 2'h0);
  property p_step0;
    $rose(exec_o) |-> step_o == 16'h0;
  endproperty
  a_step0: assert property (p_step0)
    else $error("step not zero at scan start");
  property p_stepinc;
    exec_o && step_adv_i && !end_i |=> step_o == $past(step_o) + 16'h1;
  endproperty
  a_stepinc: assert property (p_stepinc)
    else $error("step did not advance");
  // Writes excluded: inhibit acts the cycle after its write
  property p_hold;
    exec_o && $past(exec_o) && !$past(acc_wr_i) |-> $stable(term_out_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("outputs moved during execution");
  property p_end;
    exec_o && end_i |=> !exec_o;
  endproperty
  a_end: assert property (p_end)
    else $error("execution went on after end");
  property p_gap;
    $fell(exec_o) |-> !exec_o ##1 !exec_o;
  endproperty
  a_gap: assert property (p_gap)
    else $error("no latch and sample phase between scans");
  property p_xwr;
    acc_wr_i && acc_addr_i.space == SP_X |=> acc_err_o;
  endproperty
  a_xwr: assert property (p_xwr)
    else $error("input write not refused");
  property p_oct;
    (acc_rd_i || acc_wr_i) && acc_addr_i.space != SP_M && bad_oct
      |=> acc_err_o;
  endproperty
  a_oct: assert property (p_oct)
    else $error("bad octal digit not refused");
  property p_yok;
    acc_rd_i && ok_y |=> !acc_err_o;
  endproperty
  a_yok: assert property (p_yok)
    else $error("valid output number refused");
  property p_runmon;
    acc_rd_i && exec_o && acc_addr_i == {SP_M, M_RUN_MON} |=> acc_rdata_o;
  endproperty
  a_runmon: assert property (p_runmon)
    else $error("run monitor low while executing");
  property p_rowr;
    acc_wr_i && acc_addr_i == {SP_M, M_INIT_PLS} |=> acc_err_o;
  endproperty
  a_rowr: assert property (p_rowr)
    else $error("write to read-only relay not refused");
  c_end: cover property (exec_o && end_i);
  c_err: cover property (acc_err_o);
  c_rd: cover property (acc_rd_i && exec_o);
endmodule

bind siirm_scan_engine siirm_scan_engine_asserts #(
  .FILT_CYCLES(FILT_CYCLES), .OSC_CYCLES(OSC_CYCLES),
  .CSCAN_CYCLES(CSCAN_CYCLES)
) u_chk (
  .mclk_i(mclk_i), .reset_i(reset_i), .exec_o(exec_o),
  .step_o(step_o), .step_adv_i(step_adv_i), .end_i(end_i),
  .acc_addr_i(acc_addr_i), .acc_wr_i(acc_wr_i), .acc_rd_i(acc_rd_i),
  .acc_rdata_o(acc_rdata_o), .acc_err_o(acc_err_o),
  .term_out_o(term_out_o)
);

// File: siirm_field_model.sv
// Purpose: Field side of the engine: switch contacts and load drivers
// Assumes: Bench sets the wanted contact states
// Notes:   Chatter inverts the contacts while asked, like a dirty switch
`timescale 1ns/1ps
module siirm_field_model
  import siirm_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic [IO_PTS-1:0] closed_i,
  input  wire logic              chatter_i,
  input  wire logic [IO_PTS-1:0] load_i,
  output logic      [IO_PTS-1:0] term_o,
  output int                     load_on_o
);
  // ****************************************************************
  // Contacts and loads
  // ****************************************************************
  // Closed circuit gives one, open gives zero
  always @(posedge mclk_i) begin
    term_o <= chatter_i ? ~closed_i : closed_i;
  end
  // Each output feeds one load contact
  always_comb begin
    load_on_o = $countones(load_i);
  end
endmodule

// File: siirm_scan_engine_test.sv
// Purpose: Self-checking bench for the scan I/O image engine
// Assumes: Shortened filter, oscillator and constant scan counts
// Notes:   Expected images live in the bench, never read from the design
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  num_errors++; $display("unexpected at %0t got %h want %h", \
  $time, (a), (b)); end end
module siirm_scan_engine_test
  import siirm_pkg::*;
;
  // ****************************************************************
  // Signals and model state
  // ****************************************************************
  logic              mclk_i = 1'b0;
  logic              reset_i = 1'b1;
  logic              run_i = 1'b1;
  logic [MNUM_W-1:0] ret_start_i = 14'h1f4;
  logic [IO_PTS-1:0] term_in;
  logic [IO_PTS-1:0] term_out_o;
  logic [IO_PTS-1:0] closed = '0;
  logic              chatter = 1'b0;
  logic              exec_o;
  logic [15:0]       step_o;
  logic              step_adv_i = 1'b0;
  logic              end_i = 1'b0;
  siirm_addr_s       acc_addr_i = '0;
  logic              acc_wdata_i = 1'b0;
  logic              acc_wr_i = 1'b0;
  logic              acc_rd_i = 1'b0;
  logic              acc_rdata_o;
  logic              acc_err_o;
  logic              rd;
  logic              er;
  logic [IO_PTS-1:0] tout;
  logic [IO_PTS-1:0] y_m = '0;
  logic [IO_PTS-1:0] x_m = '0;
  logic [15:0]       seed = 16'hdfa;
  logic [7:0]        idx;
  logic [7:0]        tbl [3] = '{8'h0f, 8'h10, 8'hff};
  int                yq [$];
  int                load_on;
  int                num_errors = 0;
  int                comparisons = 0;
  int                wc;
  int                i;
  // Clock of 25 ns
  always #12.5 mclk_i = ~mclk_i;
  siirm_scan_engine #(.FILT_CYCLES(4), .OSC_CYCLES(8), .CSCAN_CYCLES(64))
  uut (
    .mclk_i(mclk_i), .reset_i(reset_i), .run_i(run_i),
    .ret_start_i(ret_start_i), .term_in_i(term_in),
    .term_out_o(term_out_o), .exec_o(exec_o), .step_o(step_o),
    .step_adv_i(step_adv_i), .end_i(end_i), .acc_addr_i(acc_addr_i),
    .acc_wdata_i(acc_wdata_i), .acc_wr_i(acc_wr_i), .acc_rd_i(acc_rd_i),
    .acc_rdata_o(acc_rdata_o), .acc_err_o(acc_err_o)
  );
  siirm_field_model u_field (
    .mclk_i(mclk_i), .closed_i(closed), .chatter_i(chatter),
    .load_i(term_out_o), .term_o(term_in), .load_on_o(load_on)
  );
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Relay index to three octal digit nibbles
  function automatic logic [13:0] oct(input logic [7:0] v);
    return {4'h0, v[7:6], 1'b0, v[5:3], 1'b0, v[2:0]};
  endfunction
  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One access; answer taken one cycle later, then a spare cycle
  task automatic acc(input siirm_space_e sp, input logic [13:0] n,
                     input logic w, input logic d);
    acc_addr_i <= {sp, n};
    acc_wr_i <= w;
    acc_rd_i <= !w;
    acc_wdata_i <= d;
    @(posedge mclk_i);
    acc_wr_i <= 1'b0;
    acc_rd_i <= 1'b0;
    #1 rd = acc_rdata_o;
    er = acc_err_o;
    tout = term_out_o;
    @(posedge mclk_i);
  endtask
  // Bound covers the general relay wipe after power-up, about 500 cycles
  task automatic wait_exec();
    for (wc = 0; wc < 600; wc++) begin
      @(posedge mclk_i);
      #1;
      if (exec_o === 1'b1) break;
    end
    if (exec_o !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    `CHK(step_o, 16'h0)
    @(posedge mclk_i);
  endtask
  task automatic end_scan();
    end_i <= 1'b1;
    @(posedge mclk_i);
    end_i <= 1'b0;
    wait_exec();
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    #1 `CHK(term_out_o, 256'h0)
    wait_exec();
    // Stimulus only names special relays that have a function
    acc(SP_M, M_RUN_MON, 1'b0, 1'b0);
    `CHK(rd, 1'b1)
    acc(SP_M, M_INIT_PLS, 1'b0, 1'b0);
    `CHK(rd, 1'b1)
    $display("test power-up done");
    for (i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      idx = (i < 3) ? tbl[i] : seed[7:0];
      acc(SP_Y, oct(idx), 1'b1, seed[9]);
      y_m[idx] = seed[9];
      yq.push_back(idx);
      acc(SP_Y, oct(idx), 1'b0, 1'b0);
      `CHK(rd, y_m[idx])
    end
    acc(SP_Y, 14'h018, 1'b0, 1'b0);
    `CHK(er, 1'b1)
    acc(SP_Y, 14'h400, 1'b0, 1'b0);
    `CHK(er, 1'b1)
    for (i = 0; i < 3; i++) begin
      step_adv_i <= 1'b1;
      @(posedge mclk_i);
    end
    step_adv_i <= 1'b0;
    #1 `CHK(step_o, 16'h3)
    `CHK(term_out_o, 256'h0)
    @(posedge mclk_i);
    end_scan();
    `CHK(term_out_o, y_m)
    `CHK(load_on, $countones(y_m))
    $display("test outputs done");
    closed <= {16{seed}};
    repeat (10) @(posedge mclk_i);
    for (i = 0; i < 4; i++) begin
      idx = closed[i*8 +: 8];
      acc(SP_X, oct(idx), 1'b0, 1'b0);
      `CHK(rd, x_m[idx])
    end
    end_scan();
    x_m = closed;
    for (i = 0; i < 4; i++) begin
      idx = closed[i*8 +: 8];
      acc(SP_X, oct(idx), 1'b0, 1'b0);
      `CHK(rd, x_m[idx])
    end
    chatter <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chatter <= 1'b0;
    repeat (4) @(posedge mclk_i);
    end_scan();
    acc(SP_X, oct(8'h05), 1'b1, ~x_m[5]);
    `CHK(er, 1'b1)
    acc(SP_X, oct(8'h05), 1'b0, 1'b0);
    `CHK(rd, x_m[5])
    $display("test inputs done");
    acc(SP_M, M_OUT_INH, 1'b1, 1'b1);
    `CHK(tout, 256'h0)
    end_scan();
    `CHK(term_out_o, 256'h0)
    acc(SP_M, M_OUT_INH, 1'b1, 1'b0);
    `CHK(tout, y_m)
    acc(SP_M, M_OSC_100, 1'b0, 1'b0);
    idx[0] = rd;
    repeat (6) @(posedge mclk_i);
    acc(SP_M, M_OSC_100, 1'b0, 1'b0);
    `CHK(rd, ~idx[0])
    end_scan();
    acc(SP_M, M_CONST_SCN, 1'b1, 1'b1);
    end_scan();
    `CHK((wc > 20) && (wc < 70), 1'b1)
    acc(SP_M, M_CONST_SCN, 1'b1, 1'b0);
    $display("test controls done");
    acc(SP_M, 14'h064, 1'b1, 1'b1);
    acc(SP_M, 14'h258, 1'b1, 1'b1);
    acc(SP_M, M_FIX_START, 1'b1, 1'b1);
    reset_i <= 1'b1;
    repeat (12) @(posedge mclk_i);
    #1 `CHK(term_out_o, 256'h0)
    @(posedge mclk_i);
    reset_i <= 1'b0;
    wait_exec();
    acc(SP_M, 14'h064, 1'b0, 1'b0);
    `CHK(rd, 1'b0)
    acc(SP_M, 14'h258, 1'b0, 1'b0);
    `CHK(rd, 1'b1)
    acc(SP_M, M_FIX_START, 1'b0, 1'b0);
    `CHK(rd, 1'b1)
    foreach (yq[k]) begin
      acc(SP_Y, oct(yq[k][7:0]), 1'b0, 1'b0);
      `CHK(rd, 1'b0)
    end
    $display("test power loss done");
    run_i <= 1'b0;
    end_i <= 1'b1;
    @(posedge mclk_i);
    end_i <= 1'b0;
    repeat (20) @(posedge mclk_i);
    #1 `CHK(exec_o, 1'b0)
    @(posedge mclk_i);
    acc(SP_M, M_RUN_MON, 1'b0, 1'b0);
    `CHK(rd, 1'b0)
    $display("test stop done");
    stop_test();
  end
endmodule
